// file: hw/clk_supervisor_consts.svh
/*
 * Constants of the clock selection and supervision block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the design modules and the testbench.
 */
`ifndef CLK_SUPERVISOR_CONSTS_SVH
`define CLK_SUPERVISOR_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define OFF_CTRL      8'h00
`define OFF_DIV       8'h04
`define OFF_STATUS    8'h08
`define OFF_IRQ_STAT  8'h0C
`define OFF_IRQ_MASK  8'h10
`define OFF_BOOT      8'h14

// ==========================================================================
// Control fields
`define CTRL_SEL_LSB     0
`define CTRL_EXT_EN_BIT  2
`define CTRL_PLL_EN_BIT  3
`define CTRL_MON_EN_BIT  4
`define CTRL_USB_EN_BIT  5
`define CTRL_RESET       32'h0000_0000

// Divider fields: ahb [2:0], fast apb [6:4], slow apb [9:7]
`define DIV_AHB_LSB    0
`define DIV_FAST_LSB   4
`define DIV_SLOW_LSB   7
`define DIV_RESET      32'h0000_0000

// Interrupt bits
`define IRQ_EXT_FAIL   0
`define IRQ_PLL_FAIL   1

// ==========================================================================
// Monitor timing: an edge must appear within this many ns
`define MON_WINDOW_NS  1000
`define CLK_PERIOD_NS  10
`define MON_CYCLES     (`MON_WINDOW_NS / `CLK_PERIOD_NS)

`endif

// file: hw/clk_supervisor_pkg.sv
/*
 * Types of the clock selection and supervision block.
 * Assumes nothing beyond the constants header.
 */
package clk_supervisor_pkg;
	// System clock source selection
	typedef enum logic [1:0] {
		SRC_INTERNAL = 2'b00,
		SRC_EXTERNAL = 2'b01,
		SRC_PLL      = 2'b10
	} clk_src_t;

	// Boot target from the boot pins
	typedef enum logic [1:0] {
		BOOT_USER_FLASH = 2'b00,
		BOOT_SYSTEM_MEM = 2'b01,
		BOOT_SRAM       = 2'b11
	} boot_sel_t;

	// One-hot state of the clock switch
	typedef enum logic [2:0] {
		ST_INTERNAL = 3'b001,
		ST_EXTERNAL = 3'b010,
		ST_PLL      = 3'b100
	} sw_state_t;
endpackage

// file: hw/clk_activity_monitor.sv
/*
 * Activity monitor: watches a sampled clock-present toggle and reports a
 * one-cycle failure pulse when no change is seen within the window.
 * Assumes the watched level is synchronous to hclk.
 */
`timescale 1ns/10ps
`include "clk_supervisor_consts.svh"
module clk_activity_monitor #(
	parameter int WINDOW = `MON_CYCLES
) (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Watch
	input  wire logic enable,
	input  wire logic activity,
	output logic      fail_pulse
);
	logic [15:0] cnt_q;
	logic        last_q;
	logic        fired_q;

	// ==========================================================================
	// Count cycles since the last change; fire once per outage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q   <= 16'h0000;
			last_q  <= 1'b0;
			fired_q <= 1'b0;
		end else begin
			last_q <= activity;
			if (!enable || activity != last_q) begin
				cnt_q   <= 16'h0000;
				fired_q <= 1'b0;
			end else if (cnt_q >= 16'(WINDOW - 1)) begin
				fired_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end

	// Pulse only on the first cycle the count reaches the window
	assign fail_pulse = enable && !fired_q && activity == last_q
		&& cnt_q >= 16'(WINDOW - 1);

	property p_fire_once;
		@(posedge hclk) disable iff (!hresetn)
		fail_pulse |=> !fail_pulse;
	endproperty
	a_fire_once: assert property (p_fire_once)
		else $error("monitor fired twice");
endmodule // clk_activity_monitor

// file: hw/clk_supervisor.sv
/*
 * Clock selection and supervision: system clock switch with failover to the
 * internal RC, failure interrupts, bus dividers as enables, USB gating,
 * a fixed flash-interface clock and boot pin capture. AHB-Lite slave.
 * Assumes oscillator activity toggles arrive synchronous to hclk.
 */
`timescale 1ns/10ps
`include "clk_supervisor_consts.svh"
module clk_supervisor
	import clk_supervisor_pkg::*;
#(
	parameter int MON_WINDOW = `MON_CYCLES
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Oscillator activity (toggles while running) and PLL lock
	input  wire logic        external_hs_oscillator,
	input  wire logic        pll_activity,
	input  wire logic        pll_locked,
	// Boot pins
	input  wire logic [1:0]  boot_pins,
	// Clock outputs, boot target and interrupt
	output logic [1:0]       sysclk_sel,
	output logic             flash_iface_clock,
	output logic             usb_function_clock,
	output logic             ahb_clk_en,
	output logic             fast_peripheral_bus,
	output logic             slow_peripheral_bus,
	output logic [1:0]       boot_target,
	output logic             irq
);
	// ==========================================================================
	// Registers
	logic [31:0] ctrl_q;
	logic [31:0] div_q;
	logic [1:0]  irq_stat_q;
	logic [1:0]  irq_mask_q;
	logic        fallback_q;
	sw_state_t   st_q;
	boot_sel_t   boot_q;
	logic        boot_taken_q;
	logic        ext_fail;
	logic        pll_fail;
	logic        ext_mon_en;
	logic        pll_mon_en;

	// Bus data phase capture
	logic        dp_wr_q;
	logic        dp_rd_q;
	logic [7:0]  dp_addr_q;
	logic        wr_sel;
	logic [1:0]  req_src;

	// Function: two log2 steps added; held at 7 so a large sum never wraps fast
	function automatic logic [2:0] div_sum(input logic [2:0] x, input logic [2:0] y);
		logic [3:0] s;
		s = {1'b0, x} + {1'b0, y};
		return s[3] ? 3'h7 : s[2:0];
	endfunction

	// Function: one cycle enable every 2**n cycles
	function automatic logic div_hit(input logic [7:0] c, input logic [2:0] n);
		logic [7:0] m;
		m = (8'h01 << n) - 8'h01;
		return (c & m) == 8'h00;
	endfunction

	// ==========================================================================
	// AHB-Lite address phase; zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_q   <= 1'b0;
			dp_rd_q   <= 1'b0;
			dp_addr_q <= 8'h00;
		end else if (hready) begin
			dp_wr_q   <= hsel && htrans[1] && hwrite;
			dp_rd_q   <= hsel && htrans[1] && !hwrite;
			dp_addr_q <= haddr;
		end
	end

	// Read mux, registered is unnecessary: data phase is one cycle
	always_comb begin
		hrdata = 32'h0000_0000;
		if (dp_rd_q) begin
			unique case (dp_addr_q)
				`OFF_CTRL:     hrdata = ctrl_q;
				`OFF_DIV:      hrdata = div_q;
				`OFF_STATUS:   hrdata = {26'h0, fallback_q, pll_locked, st_q[2],
					st_q[1], sysclk_sel};
				`OFF_IRQ_STAT: hrdata = {30'h0, irq_stat_q};
				`OFF_IRQ_MASK: hrdata = {30'h0, irq_mask_q};
				`OFF_BOOT:     hrdata = {30'h0, boot_q};
				default:       hrdata = 32'h0000_0000;
			endcase
		end
	end

	assign wr_sel  = dp_wr_q && dp_addr_q == `OFF_CTRL;
	assign req_src = hwdata[`CTRL_SEL_LSB +: 2];

	// ==========================================================================
	// Control and divider registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= `CTRL_RESET;
			div_q  <= `DIV_RESET;
		end else begin
			if (wr_sel)
				ctrl_q <= {26'h0, hwdata[5:0]};
			if (dp_wr_q && dp_addr_q == `OFF_DIV)
				div_q <= {22'h0, hwdata[9:0]};
			// Failover rewrites the selection so a read shows internal RC;
			// it beats a same-cycle write, as the clock switch does
			if (ext_fail || pll_fail)
				ctrl_q[`CTRL_SEL_LSB +: 2] <= SRC_INTERNAL;
		end
	end

	// ==========================================================================
	// Supervision of external oscillator and PLL input
	assign ext_mon_en = ctrl_q[`CTRL_MON_EN_BIT] && ctrl_q[`CTRL_EXT_EN_BIT]
		&& st_q != ST_INTERNAL;
	assign pll_mon_en = ctrl_q[`CTRL_MON_EN_BIT] && ctrl_q[`CTRL_PLL_EN_BIT]
		&& st_q == ST_PLL;

	clk_activity_monitor #(
		.WINDOW(MON_WINDOW)
	) u_ext_mon (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.enable    (ext_mon_en),
		.activity  (external_hs_oscillator),
		.fail_pulse(ext_fail)
	);

	clk_activity_monitor #(
		.WINDOW(MON_WINDOW)
	) u_pll_mon (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.enable    (pll_mon_en),
		.activity  (pll_activity),
		.fail_pulse(pll_fail)
	);

	// ==========================================================================
	// Clock switch; failure wins over a same-cycle selection write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q       <= ST_INTERNAL;
			fallback_q <= 1'b0;
		end else if (ext_fail || pll_fail) begin
			st_q       <= ST_INTERNAL;
			fallback_q <= 1'b1;
		end else if (wr_sel) begin
			fallback_q <= 1'b0;
			unique case (req_src)
				SRC_EXTERNAL: st_q <= hwdata[`CTRL_EXT_EN_BIT] ? ST_EXTERNAL : ST_INTERNAL;
				SRC_PLL:      st_q <= (hwdata[`CTRL_PLL_EN_BIT] && pll_locked) ?
					ST_PLL : ST_INTERNAL;
				default:      st_q <= ST_INTERNAL;
			endcase
		end
	end

	always_comb begin
		unique case (st_q)
			ST_EXTERNAL: sysclk_sel = SRC_EXTERNAL;
			ST_PLL:      sysclk_sel = SRC_PLL;
			default:     sysclk_sel = SRC_INTERNAL;
		endcase
	end

	// Flash interface never follows the system switch
	assign flash_iface_clock = 1'b1;

	// USB clock only with external oscillator and PLL both on
	assign usb_function_clock = ctrl_q[`CTRL_USB_EN_BIT] && ctrl_q[`CTRL_EXT_EN_BIT]
		&& ctrl_q[`CTRL_PLL_EN_BIT] && pll_locked;

	// ==========================================================================
	// Interrupt status: set wins over write-one-to-clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_q <= 2'b00;
			irq_mask_q <= 2'b00;
		end else begin
			if (dp_wr_q && dp_addr_q == `OFF_IRQ_MASK)
				irq_mask_q <= hwdata[1:0];
			irq_stat_q <= ((dp_wr_q && dp_addr_q == `OFF_IRQ_STAT) ?
				(irq_stat_q & ~hwdata[1:0]) : irq_stat_q)
				| {pll_fail, ext_fail};
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	// ==========================================================================
	// Bus clock enables from a free-running count; fast/slow APB are
	// subdivisions of the AHB rate
	logic [7:0] div_cnt_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			div_cnt_q <= 8'h00;
		else
			div_cnt_q <= div_cnt_q + 8'h01;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ahb_clk_en          <= 1'b0;
			fast_peripheral_bus <= 1'b0;
			slow_peripheral_bus <= 1'b0;
		end else begin
			ahb_clk_en          <= div_hit(div_cnt_q, div_q[2:0]);
			fast_peripheral_bus <= div_hit(div_cnt_q, div_sum(div_q[2:0], div_q[6:4]));
			slow_peripheral_bus <= div_hit(div_cnt_q, div_sum(div_q[2:0], div_q[9:7]));
		end
	end

	// ==========================================================================
	// Boot pins captured at the first clock after reset release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			boot_q       <= BOOT_USER_FLASH;
			boot_taken_q <= 1'b0;
		end else if (!boot_taken_q) begin
			boot_taken_q <= 1'b1;
			unique case (boot_pins)
				2'b01:   boot_q <= BOOT_SYSTEM_MEM;
				2'b11:   boot_q <= BOOT_SRAM;
				default: boot_q <= BOOT_USER_FLASH;
			endcase
		end
	end
	assign boot_target = boot_q;

	// ==========================================================================
	// Checks
	property p_fail_to_internal;
		@(posedge hclk) disable iff (!hresetn)
		(ext_fail || pll_fail) |=> sysclk_sel == SRC_INTERNAL && fallback_q;
	endproperty
	a_fail_to_internal: assert property (p_fail_to_internal)
		else $error("no fallback after failure");

	property p_irq_masked;
		@(posedge hclk) disable iff (!hresetn)
		(ext_fail && !irq_mask_q[0] && !irq_stat_q[1]) |=> !irq || irq_mask_q[0];
	endproperty
	a_irq_masked: assert property (p_irq_masked)
		else $error("interrupt raised while masked");

	property p_irq_raised;
		@(posedge hclk) disable iff (!hresetn)
		(ext_fail && irq_mask_q[0]) |=> irq;
	endproperty
	a_irq_raised: assert property (p_irq_raised)
		else $error("enabled failure gave no interrupt");

	property p_pll_flag;
		@(posedge hclk) disable iff (!hresetn)
		pll_fail |=> irq_stat_q[1];
	endproperty
	a_pll_flag: assert property (p_pll_flag)
		else $error("pll failure not flagged");

	property p_ext_flag;
		@(posedge hclk) disable iff (!hresetn)
		ext_fail |=> irq_stat_q[0];
	endproperty
	a_ext_flag: assert property (p_ext_flag)
		else $error("external failure not flagged");

	property p_fallback_clear;
		@(posedge hclk) disable iff (!hresetn)
		(wr_sel && !ext_fail && !pll_fail) |=> !fallback_q;
	endproperty
	a_fallback_clear: assert property (p_fallback_clear)
		else $error("fallback kept after reselect");

	property p_sticky;
		@(posedge hclk) disable iff (!hresetn)
		(fallback_q && !wr_sel) |=> fallback_q && sysclk_sel == SRC_INTERNAL;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("fallback left without software");

	property p_usb_gate;
		@(posedge hclk) disable iff (!hresetn)
		usb_function_clock |-> ctrl_q[`CTRL_EXT_EN_BIT] && ctrl_q[`CTRL_PLL_EN_BIT];
	endproperty
	a_usb_gate: assert property (p_usb_gate)
		else $error("usb clock without oscillator and pll");

	property p_boot_stable;
		@(posedge hclk) disable iff (!hresetn)
		boot_taken_q |=> $stable(boot_q);
	endproperty
	a_boot_stable: assert property (p_boot_stable)
		else $error("boot target changed after startup");

	property p_ahb_en;
		@(posedge hclk) disable iff (!hresetn)
		div_q[2:0] == 3'h0 |=> ahb_clk_en;
	endproperty
	a_ahb_en: assert property (p_ahb_en)
		else $error("undivided ahb enable missing");

	property p_reset_internal;
		@(posedge hclk) $rose(hresetn) |-> sysclk_sel == SRC_INTERNAL;
	endproperty
	a_reset_internal: assert property (p_reset_internal)
		else $error("not on internal rc after reset");
endmodule // clk_supervisor

// file: tb/osc_model.sv
/*
 * Far-side model: external oscillator and PLL activity toggles plus PLL lock.
 * Assumes the bench starts and stops each source just after an hclk edge.
 */
`timescale 1ns/10ps
module osc_model (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Run controls from the bench
	input  wire logic ext_run,
	input  wire logic pll_run,
	// Activity and lock toward the block
	output logic      ext_act,
	output logic      pll_act,
	output logic      pll_lock
);
	// ======================================================================
	// Activity toggles only while running; a dead source stands still
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_act <= 1'b0;
			pll_act <= 1'b0;
		end else begin
			ext_act <= ext_run ? ~ext_act : ext_act;
			pll_act <= (pll_run && ext_run) ? ~pll_act : pll_act;
		end
	end
	// PLL only locks when fed by a live external source
	assign pll_lock = pll_run && ext_run;
endmodule // osc_model

// file: tb/clk_supervisor_tb.sv
/*
 * Self-checking bench of the clock supervisor: AHB-Lite register access,
 * failover, interrupts, dividers, USB gating and boot capture.
 * Assumes hreadyout feeds hready and the oscillator model in osc_model.sv.
 */
`timescale 1ns/10ps
`include "clk_supervisor_consts.svh"
module clk_supervisor_tb;
	import clk_supervisor_pkg::*;
	localparam int MW = 8;
	// ======================================================================
	// Signals
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'b00, boot_pins = 2'b00, sysclk_sel, boot_target;
	logic [2:0]  hsize = 3'b010;
	logic [31:0] hwdata = 32'h0000_0000, hrdata;
	logic        hreadyout, hresp, ext_act, pll_act, pll_lock, irq;
	logic        flash_iface_clock, usb_function_clock, ahb_clk_en;
	logic        fast_peripheral_bus, slow_peripheral_bus;
	logic        ext_run = 1'b0, pll_run = 1'b0;
	int          failures = 0, checked = 0;

	always #5 hclk = ~hclk;

	clk_supervisor #(.MON_WINDOW(MW)) clk_supervisor_i (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .external_hs_oscillator(ext_act), .pll_activity(pll_act),
		.pll_locked(pll_lock), .boot_pins(boot_pins), .sysclk_sel(sysclk_sel),
		.flash_iface_clock(flash_iface_clock), .usb_function_clock(usb_function_clock),
		.ahb_clk_en(ahb_clk_en), .fast_peripheral_bus(fast_peripheral_bus),
		.slow_peripheral_bus(slow_peripheral_bus), .boot_target(boot_target), .irq(irq));

	osc_model osc_model_i (.hclk(hclk), .hresetn(hresetn), .ext_run(ext_run),
		.pll_run(pll_run), .ext_act(ext_act), .pll_act(pll_act), .pll_lock(pll_lock));

	// ======================================================================
	// Checking and closing
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Enables seen in 256 cycles for a combined log2 divide; steps stop at 7
	function automatic int exp_cnt(input int n);
		return 256 >> (n > 7 ? 7 : n);
	endfunction

	task automatic results();
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ======================================================================
	// Bus master; data sampled at the negedge so the closing edge is race free
	task automatic wait_rdy(output logic [31:0] d);
		int n;
		n = 0;
		do begin
			@(negedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		d = hrdata;
		if (n >= 50) begin
			failures++;
			results();
		end
		@(posedge hclk);
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		logic [31:0] x;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		wait_rdy(x);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy(rd);
		// Let outputs launched by the closing edge settle before callers look
		@(negedge hclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h0000_0000, x);
		chk(x, exp);
	endtask

	// Bounded wait for the fall-back; lo is the earliest legal cycle count
	task automatic wait_sel0(input int lo);
		int n;
		n = 0;
		while (sysclk_sel !== 2'd0 && n < 4 * MW) begin
			@(negedge hclk);
			n++;
		end
		chk(32'(n >= lo && n < 4 * MW), 32'h0000_0001);
	endtask

	// ======================================================================
	// Main sequence
	initial begin
		logic [1:0] tbl [3];
		int a, f, s, ca, cf, cs;
		tbl = '{2'b00, 2'b01, 2'b11};
		void'($urandom(4520));
		boot_pins = tbl[$urandom_range(2)];
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(negedge hclk);
		chk(32'(sysclk_sel), 32'h0000_0000);
		chk(32'(boot_target), 32'(boot_pins));
		chk(32'(flash_iface_clock), 32'h0000_0001);
		chk(32'(hresp), 32'h0000_0000);
		chk(32'(hreadyout), 32'h0000_0001);
		rdc(`OFF_CTRL, `CTRL_RESET);
		rdc(`OFF_DIV, `DIV_RESET);
		wr(8'h18, 32'hFFFF_FFFF);
		rdc(8'h18, 32'h0000_0000);
		// External source selected, then killed
		ext_run <= 1'b1;
		wr(`OFF_CTRL, 32'h0000_0015);
		chk(32'(sysclk_sel), 32'h0000_0001);
		rdc(`OFF_STATUS, 32'h0000_0005);
		ext_run <= 1'b0;
		wait_sel0(MW - 1);
		chk(32'(irq), 32'h0000_0000);
		chk(32'(flash_iface_clock), 32'h0000_0001);
		rdc(`OFF_STATUS, 32'h0000_0020);
		rdc(`OFF_IRQ_STAT, 32'h0000_0001);
		ext_run <= 1'b1;
		repeat (2 * MW) @(posedge hclk);
		chk(32'(sysclk_sel), 32'h0000_0000);
		wr(`OFF_IRQ_MASK, 32'h0000_0001);
		chk(32'(irq), 32'h0000_0001);
		wr(`OFF_IRQ_STAT, 32'h0000_0001);
		chk(32'(irq), 32'h0000_0000);
		// PLL selected with USB, then PLL killed
		pll_run <= 1'b1;
		wr(`OFF_CTRL, 32'h0000_003E);
		chk(32'(sysclk_sel), 32'h0000_0002);
		chk(32'(usb_function_clock), 32'h0000_0001);
		wr(`OFF_CTRL, 32'h0000_003A);
		chk(32'(usb_function_clock), 32'h0000_0000);
		wr(`OFF_CTRL, 32'h0000_003E);
		pll_run <= 1'b0;
		wait_sel0(MW - 1);
		rdc(`OFF_IRQ_STAT, 32'h0000_0002);
		chk(32'(irq), 32'h0000_0000);
		wr(`OFF_IRQ_MASK, 32'h0000_0003);
		chk(32'(irq), 32'h0000_0001);
		wr(`OFF_IRQ_STAT, 32'h0000_0002);
		chk(32'(irq), 32'h0000_0000);
		// Dividers: power-of-two enables, all zero first, all maximum last
		for (int i = 0; i < 5; i++) begin
			a = i == 0 ? 0 : i == 4 ? 7 : $urandom_range(3);
			f = i == 0 ? 0 : i == 4 ? 7 : $urandom_range(3);
			s = i == 0 ? 0 : i == 4 ? 7 : $urandom_range(3);
			wr(`OFF_DIV, 32'(a) | (32'(f) << 4) | (32'(s) << 7));
			repeat (70) @(posedge hclk);
			ca = 0;
			cf = 0;
			cs = 0;
			repeat (256) begin
				@(negedge hclk);
				ca += int'(ahb_clk_en);
				cf += int'(fast_peripheral_bus);
				cs += int'(slow_peripheral_bus);
			end
			chk(32'(ca), 32'(exp_cnt(a)));
			chk(32'(cf), 32'(exp_cnt(a + f)));
			chk(32'(cs), 32'(exp_cnt(a + s)));
		end
		// Reset in mid-run returns to the internal RC
		wr(`OFF_CTRL, 32'h0000_0015);
		hresetn <= 1'b0;
		@(negedge hclk);
		chk(32'(sysclk_sel), 32'h0000_0000);
		@(posedge hclk);
		hresetn <= 1'b1;
		rdc(`OFF_CTRL, `CTRL_RESET);
		results();
	end

	// Hang guard
	initial begin
		#900_000;
		failures++;
		results();
	end
endmodule // clk_supervisor_tb
